// *** common/gpmc_consts.svh ***
// constants for the general pin pair mode control block
`ifndef GPMC_CONSTS_SVH
`define GPMC_CONSTS_SVH
`define GPMC_CFG_OFFSET 8'h0e
`define GPMC_CFG_RESET 8'h00
`define GPMC_PIN2_VAL_BIT 7
`define GPMC_PIN2_MODE_HI 6
`define GPMC_PIN2_MODE_LO 4
`define GPMC_PIN1_VAL_BIT 3
`define GPMC_PIN1_MODE_HI 2
`define GPMC_PIN1_MODE_LO 0
`endif

// *** common/gpmc_pkg.sv ***
// types for the general pin pair mode control block
`default_nettype none
package gpmc_pkg;
  typedef enum logic [2:0] {
    GPMC_MODE_FUNC = 3'h0,
    GPMC_MODE_OUT = 3'h1,
    GPMC_MODE_HIZ = 3'h2,
    GPMC_MODE_IN = 3'h3,
    GPMC_MODE_FUNC_B = 3'h4,
    GPMC_MODE_RHOLD = 3'h5,
    GPMC_MODE_HIZ_B = 3'h6,
    GPMC_MODE_RDEF = 3'h7
  } gpmc_mode_t;
  typedef struct packed {
    logic out_val;
    logic out_en;
    logic func_sel;
  } gpmc_pin_drive_t;
endpackage : gpmc_pkg
`default_nettype wire

// *** core/gpmc_top.sv ***
// pin pair mode control: config register, remote value capture, pin drive
`timescale 1ns/1ps
`default_nettype none
`include "gpmc_consts.svh"
module gpmc_top import gpmc_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic SECOND_PORT_SELECT,
  output logic [7:0] REG_RDATA,
  // link status and back channel per port
  input wire logic [1:0] LINK_LOST,
  input wire logic [1:0] REMOTE_FRAME_VALID,
  input wire logic [1:0] REMOTE_PIN_ONE,
  input wire logic [1:0] REMOTE_PIN_TWO,
  // first port pins
  input wire logic GENERAL_PIN_ONE_I,
  output logic GENERAL_PIN_ONE_O,
  output logic GENERAL_PIN_ONE_OE,
  output logic GENERAL_PIN_ONE_FUNC,
  input wire logic GENERAL_PIN_TWO_I,
  output logic GENERAL_PIN_TWO_O,
  output logic GENERAL_PIN_TWO_OE,
  output logic GENERAL_PIN_TWO_FUNC,
  // second port pins
  input wire logic SECOND_PORT_PIN_ONE_I,
  output logic SECOND_PORT_PIN_ONE_O,
  output logic SECOND_PORT_PIN_ONE_OE,
  output logic SECOND_PORT_PIN_ONE_FUNC,
  input wire logic SECOND_PORT_PIN_TWO_I,
  output logic SECOND_PORT_PIN_TWO_O,
  output logic SECOND_PORT_PIN_TWO_OE,
  output logic SECOND_PORT_PIN_TWO_FUNC,
  // sampled input levels, pin1 in bit 0, pin2 in bit 1, per port
  output logic [1:0] PORT0_PIN_IN,
  output logic [1:0] PORT1_PIN_IN
);
  // ==========================================================
  // decode
  function automatic gpmc_pin_drive_t gpmc_decode(input logic [2:0] mode, input logic val,
                                                  input logic rem, input logic lost);
    gpmc_pin_drive_t d;
    d = '{out_val: 1'b0, out_en: 1'b0, func_sel: 1'b0};
    unique case (gpmc_mode_t'(mode))
      GPMC_MODE_FUNC, GPMC_MODE_FUNC_B: d.func_sel = 1'b1;
      // x10 only releases the pin; x00 also hands it to its function
      GPMC_MODE_HIZ, GPMC_MODE_HIZ_B: d.out_en = 1'b0;
      GPMC_MODE_OUT: begin
        d.out_en = 1'b1;
        d.out_val = val;
      end
      GPMC_MODE_IN: d.out_en = 1'b0;
      GPMC_MODE_RHOLD: begin
        d.out_en = 1'b1;
        d.out_val = rem;
      end
      GPMC_MODE_RDEF: begin
        d.out_en = 1'b1;
        d.out_val = lost ? val : rem;
      end
    endcase
    return d;
  endfunction : gpmc_decode

  // ==========================================================
  // address decode
  // one mapped address, asked by both the write and the read path
  function automatic logic gpmc_cfg_hit(input logic [7:0] addr);
    return addr == `GPMC_CFG_OFFSET;
  endfunction : gpmc_cfg_hit

  // ==========================================================
  // configuration registers, one copy per port
  logic [7:0] cfg_ff [2];
  logic [7:0] nxt_cfg [2];
  logic [1:0] rem_one_ff, rem_two_ff, nxt_rem_one, nxt_rem_two;
  logic [7:0] rdata_ff, nxt_rdata;
  logic sel;
  assign sel = SECOND_PORT_SELECT;

  // each port keeps its own copy; the select only picks which one an access sees
  // the select is a level and must be steady across the access edge
  // a read in the same cycle as a write returns the old contents
  always_comb begin
    nxt_cfg[0] = cfg_ff[0];
    nxt_cfg[1] = cfg_ff[1];
    nxt_rdata = rdata_ff;
    if (REG_WR && gpmc_cfg_hit(REG_ADDR)) begin
      nxt_cfg[sel] = REG_WDATA;
    end
    if (REG_RD) begin
      // unmapped reads give zero rather than the previous word
      nxt_rdata = gpmc_cfg_hit(REG_ADDR) ? cfg_ff[sel] : 8'h00;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cfg_ff[0] <= `GPMC_CFG_RESET;
      cfg_ff[1] <= `GPMC_CFG_RESET;
      rdata_ff <= 8'h00;
    end else begin
      cfg_ff[0] <= nxt_cfg[0];
      cfg_ff[1] <= nxt_cfg[1];
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // remote pin values, only refreshed by valid frames so loss holds them
  // a frame carries both pins of one port; a frame seen during loss still lands
  always_comb begin
    nxt_rem_one = rem_one_ff;
    nxt_rem_two = rem_two_ff;
    for (int p = 0; p < 2; p++) begin
      if (REMOTE_FRAME_VALID[p]) begin
        nxt_rem_one[p] = REMOTE_PIN_ONE[p];
        nxt_rem_two[p] = REMOTE_PIN_TWO[p];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rem_one_ff <= 2'h0;
      rem_two_ff <= 2'h0;
    end else begin
      rem_one_ff <= nxt_rem_one;
      rem_two_ff <= nxt_rem_two;
    end
  end

  // ==========================================================
  // pin drive
  // entries 0 and 1 are pin one and two of port 0, entries 2 and 3 those of port 1
  // link loss is taken unfiltered; it reaches the pin one edge after it is seen
  // a write reaches the pins two edges after it is taken
  gpmc_pin_drive_t drv_ff [4];
  gpmc_pin_drive_t nxt_drv [4];

  // reset drive equals mode 000, so every pin starts with its dedicated function
  localparam gpmc_pin_drive_t drv_at_reset = '{out_val: 1'b0, out_en: 1'b0, func_sel: 1'b1};
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      nxt_drv[2*p] = gpmc_decode(cfg_ff[p][`GPMC_PIN1_MODE_HI:`GPMC_PIN1_MODE_LO],
                                 cfg_ff[p][`GPMC_PIN1_VAL_BIT], rem_one_ff[p], LINK_LOST[p]);
      nxt_drv[2*p+1] = gpmc_decode(cfg_ff[p][`GPMC_PIN2_MODE_HI:`GPMC_PIN2_MODE_LO],
                                   cfg_ff[p][`GPMC_PIN2_VAL_BIT], rem_two_ff[p], LINK_LOST[p]);
    end
  end

  // decode is registered so every pin output comes from a flip-flop
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) begin
        drv_ff[i] <= drv_at_reset;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        drv_ff[i] <= nxt_drv[i];
      end
    end
  end

  // ==========================================================
  // input sampling: three stages, change taken once stages two and three agree
  // s1 may go metastable, so only s2 and s3 are compared: one more cycle of delay
  logic [3:0] s1_ff, s2_ff, s3_ff, in_ff;
  logic [3:0] nxt_in;
  logic [3:0] pin_level;
  // bit order matches the drive entries
  assign pin_level = {SECOND_PORT_PIN_TWO_I, SECOND_PORT_PIN_ONE_I, GENERAL_PIN_TWO_I, GENERAL_PIN_ONE_I};
  // a level must be seen twice alike before it is taken
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_in[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : in_ff[i];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 4'h0;
      in_ff <= 4'h0;
    end else begin
      s1_ff <= pin_level;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      in_ff <= nxt_in;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  // the output enable is high while the pin is driven
  assign REG_RDATA = rdata_ff;
  // first port pins
  assign GENERAL_PIN_ONE_O = drv_ff[0].out_val;
  assign GENERAL_PIN_ONE_OE = drv_ff[0].out_en;
  assign GENERAL_PIN_ONE_FUNC = drv_ff[0].func_sel;
  assign GENERAL_PIN_TWO_O = drv_ff[1].out_val;
  assign GENERAL_PIN_TWO_OE = drv_ff[1].out_en;
  assign GENERAL_PIN_TWO_FUNC = drv_ff[1].func_sel;

  // second port pins
  assign SECOND_PORT_PIN_ONE_O = drv_ff[2].out_val;
  assign SECOND_PORT_PIN_ONE_OE = drv_ff[2].out_en;
  assign SECOND_PORT_PIN_ONE_FUNC = drv_ff[2].func_sel;
  assign SECOND_PORT_PIN_TWO_O = drv_ff[3].out_val;
  assign SECOND_PORT_PIN_TWO_OE = drv_ff[3].out_en;
  assign SECOND_PORT_PIN_TWO_FUNC = drv_ff[3].func_sel;

  // filtered input levels
  assign PORT0_PIN_IN = in_ff[1:0];
  assign PORT1_PIN_IN = in_ff[3:2];
endmodule : gpmc_top
`default_nettype wire

// *** verif/gpmc_assertions.sv ***
// checker: pin mode decode, port steering, unmapped reads
`timescale 1ns/1ps
`default_nettype none
module gpmc_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic SECOND_PORT_SELECT,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // watched pins
  input wire logic GENERAL_PIN_ONE_O,
  input wire logic GENERAL_PIN_ONE_OE,
  input wire logic GENERAL_PIN_ONE_FUNC,
  input wire logic SECOND_PORT_PIN_ONE_O,
  input wire logic SECOND_PORT_PIN_ONE_OE,
  input wire logic SECOND_PORT_PIN_TWO_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire [7:0] d = REG_WDATA;
  wire oe = GENERAL_PIN_ONE_OE;
  wire fn = GENERAL_PIN_ONE_FUNC;
  // the settle cycle is kept free of writes; a second write there would reach the pins only after the check
  property p(s, c, e);
    REG_WR && REG_ADDR == 8'h0e && SECOND_PORT_SELECT == s && c ##1 !REG_WR |=> e;
  endproperty
  a_one_out: assert property (p(0, d[2:0] == 3'h1, oe && GENERAL_PIN_ONE_O == $past(d[3], 2)))
    else $error("output mode level");
  a_func_in: assert property (p(0, d[1:0] == 2'h0, fn && !oe)) else $error("functional mode");
  a_hiz_pin: assert property (p(0, d[1:0] == 2'h2, !fn && !oe)) else $error("high impedance mode");
  a_gp_in: assert property (p(0, d[2:0] == 3'h3, !fn && !oe)) else $error("input mode");
  a_remote_oe: assert property (p(0, d[2] && d[0], oe && !fn)) else $error("remote mode");
  a_sel_one: assert property (p(1, d[2:0] == 3'h1,
    SECOND_PORT_PIN_ONE_OE && SECOND_PORT_PIN_ONE_O == $past(d[3], 2))) else $error("second port pin one");
  a_sel_two: assert property (p(1, d[6:4] == 3'h1, SECOND_PORT_PIN_TWO_OE)) else $error("second pin two");
  a_rd_unmapped: assert property (REG_RD && REG_ADDR != 8'h0e |=> REG_RDATA == 8'h00) else $error("unmapped");
  cover property (REG_WR && d[2:0] == 3'h5);
  cover property (REG_WR && SECOND_PORT_SELECT);
  cover property (REG_RD && REG_ADDR != 8'h0e);
endmodule : gpmc_chk
bind gpmc_top gpmc_chk i_chk (.CLOCK, .RST_N, .REG_WR, .REG_RD, .SECOND_PORT_SELECT, .REG_ADDR, .REG_WDATA,
  .REG_RDATA, .GENERAL_PIN_ONE_O, .GENERAL_PIN_ONE_OE, .GENERAL_PIN_ONE_FUNC, .SECOND_PORT_PIN_ONE_O,
  .SECOND_PORT_PIN_ONE_OE, .SECOND_PORT_PIN_TWO_OE);
`default_nettype wire

// *** verif/gpmc_far_side.sv ***
// far side: link status and back-channel remote pin frames
`timescale 1ns/1ps
`default_nettype none
module gpmc_far_side (
  // clock
  input wire logic clk,
  // link status and back channel, one bit per port
  output logic [1:0] lost,
  output logic [1:0] fv,
  output logic [1:0] r1,
  output logic [1:0] r2
);
  initial {lost, fv, r1, r2} = '0;
  task automatic send(input int p, input logic a, b);
    @(posedge clk) #10 {fv[p], r1[p], r2[p]} = {1'b1, a, b};
    // stale values inverted once the frame is gone
    @(posedge clk) #10 {fv[p], r1[p], r2[p]} = {1'b0, !a, !b};
  endtask : send
  task automatic link(input int p, input logic v);
    @(posedge clk) #10 lost[p] = v;
  endtask : link
endmodule : gpmc_far_side
`default_nettype wire

// *** verif/gpmc_top_bench.sv ***
// self-checking bench: register access, mode decode, remote drive, port steering
`timescale 1ns/1ps
`default_nettype none
module gpmc_top_bench;
  logic clock = 0, rst_n = 0, wr = 0, rd = 0, sel = 0, o1, e1, f1, o2, e2, f2, so1, se1, sf1, so2, se2, sf2;
  logic [7:0] addr = 0, wd = 0, rdata;
  logic [1:0] lost, fv, r1, r2, in0, in1;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  gpmc_top i_dut (.CLOCK(clock), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wd),
    .SECOND_PORT_SELECT(sel), .REG_RDATA(rdata), .LINK_LOST(lost), .REMOTE_FRAME_VALID(fv), .REMOTE_PIN_ONE(r1),
    .REMOTE_PIN_TWO(r2), .GENERAL_PIN_ONE_I(1'b1), .GENERAL_PIN_ONE_O(o1), .GENERAL_PIN_ONE_OE(e1),
    .GENERAL_PIN_ONE_FUNC(f1), .GENERAL_PIN_TWO_I(1'b0), .GENERAL_PIN_TWO_O(o2), .GENERAL_PIN_TWO_OE(e2),
    .GENERAL_PIN_TWO_FUNC(f2), .SECOND_PORT_PIN_ONE_I(1'b1), .SECOND_PORT_PIN_ONE_O(so1),
    .SECOND_PORT_PIN_ONE_OE(se1), .SECOND_PORT_PIN_ONE_FUNC(sf1), .SECOND_PORT_PIN_TWO_I(1'b0),
    .SECOND_PORT_PIN_TWO_O(so2), .SECOND_PORT_PIN_TWO_OE(se2), .SECOND_PORT_PIN_TWO_FUNC(sf2),
    .PORT0_PIN_IN(in0), .PORT1_PIN_IN(in1));
  gpmc_far_side i_far (.clk(clock), .lost(lost), .fv(fv), .r1(r1), .r2(r2));
  initial forever #50 clock = ~clock;
  task automatic chk(input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic step;
    @(posedge clock) #10;
  endtask : step
  task automatic acc(input logic w, s, input logic [7:0] a, d);
    step;
    {wr, rd, sel, addr, wd} = {w, !w, s, a, d};
    step;
    {wr, rd} = 2'b00;
  endtask : acc
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    repeat (8) step;
    rst_n = 1;
    chk({f1, e1, f2, e2, sf1, se1, sf2, se2}, 8'haa);
    acc(0, 0, 8'h0e, 8'h00);
    chk(rdata, 8'h00);
    // remote value still zero while the value bits are one
    for (int m = 0; m < 8; m++) begin
      acc(1, 0, 8'h0e, {1'b1, m[2:0], 1'b1, m[2:0]});
      step;
      chk({f1, e1, o1 & e1, f2, e2, o2 & e2}, {2{m[1:0] == 0, m[0] && m != 3, m == 1}});
    end
    chk({in1, in0}, 8'h05);
    acc(1, 0, 8'h0e, 8'hf5);
    i_far.send(0, 1, 0);
    step;
    chk({o1, o2}, 8'h02);
    i_far.link(0, 1);
    step;
    step;
    chk({o1, o2, e1, e2}, 8'h0f);
    i_far.link(0, 0);
    acc(1, 1, 8'h0e, 8'h19);
    step;
    chk({se1, so1, se2, so2, e1, o1}, 8'h3b);
    acc(0, 1, 8'h0e, 8'h00);
    chk(rdata, 8'h19);
    // port 1 remote pins: pin one remote-default, pin two remote-hold; port 0 must not follow
    acc(1, 1, 8'h0e, 8'hd7);
    i_far.send(1, 1, 0);
    step;
    chk({so1, so2, o1, o2}, 8'h0a);
    i_far.link(1, 1);
    step;
    step;
    chk({so1, so2, se1, se2, o1, o2}, 8'h0e);
    acc(1, 0, 8'h0f, 8'hff);
    acc(0, 0, 8'h0e, 8'h00);
    chk(rdata, 8'hf5);
    acc(0, 0, 8'h0f, 8'h00);
    chk(rdata, 8'h00);
    // reset in mid-run puts both copies and all pins back to mode 000
    rst_n = 0;
    step;
    step;
    rst_n = 1;
    chk({f1, e1, f2, e2, sf1, se1, sf2, se2}, 8'haa);
    acc(0, 1, 8'h0e, 8'h00);
    chk(rdata, 8'h00);
    print_verdict;
  end
endmodule : gpmc_top_bench
`default_nettype wire
